// ==== addr_field_sizer.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// decodes addressing modes into field lengths
module addr_field_sizer (
  field_sizes_if.sizer sz  // frame control in, sizes out
);

  function automatic logic [3:0] addr_len(input logic [1:0] mode);
    case (mode)
      framer_pkg::AM_SHORT: addr_len = framer_pkg::SHORT_OCTETS;
      framer_pkg::AM_EXT:   addr_len = framer_pkg::EXT_OCTETS;
      default:              addr_len = 4'h0;
    endcase
  endfunction : addr_len

  // pan fields exist only with an address; compression drops the source pan
  always_comb begin
    sz.daddr_len = addr_len(sz.fc[framer_pkg::FC_DMODE_LSB +: 2]);
    sz.saddr_len = addr_len(sz.fc[framer_pkg::FC_SMODE_LSB +: 2]);
    sz.dpan_len  = (sz.daddr_len != 4'h0) ? framer_pkg::PAN_OCTETS : 4'h0;
    sz.span_len  = ((sz.saddr_len != 4'h0) && !sz.fc[framer_pkg::FC_PANCOMP_BIT]) ?
                   framer_pkg::PAN_OCTETS : 4'h0;
  end

endmodule : addr_field_sizer
`default_nettype wire

// ==== field_sizes_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// frame control word in, address field sizes out
interface field_sizes_if;
  logic [15:0] fc;
  logic [3:0]  dpan_len;
  logic [3:0]  daddr_len;
  logic [3:0]  span_len;
  logic [3:0]  saddr_len;
  modport sizer (input fc, output dpan_len, daddr_len, span_len, saddr_len);
  modport user  (output fc, input dpan_len, daddr_len, span_len, saddr_len);
endinterface : field_sizes_if
`default_nettype wire

// ==== framer_pkg.sv ====
`default_nettype none
// ============================================================
// shared constants of the segment header framer
package framer_pkg;

  // segment control octet 0 layout
  localparam int         SC0_RES_LSB    = 4;
  localparam int         SC0_TMR_BIT    = 3;
  localparam int         SC0_CC_BIT     = 2;
  localparam int         SC0_CAP_BIT    = 1;
  localparam int         SC0_FINAL_BIT  = 0;
  localparam logic [3:0] SC0_RES_VALUE  = 4'h0;
  // segment control octet 1 layout
  localparam int         SC1_COUNT_LSB  = 2;

  // frame control word layout
  localparam int         FC_TYPE_LSB    = 0;
  localparam int         FC_ACKREQ_BIT  = 5;
  localparam int         FC_PANCOMP_BIT = 6;
  localparam int         FC_DMODE_LSB   = 10;
  localparam int         FC_VER_LSB     = 12;
  localparam int         FC_SMODE_LSB   = 14;
  localparam logic [15:0] FC_VER_MASK   = 16'hCFFF;
  localparam logic [15:0] FC_BEACON     = 16'h8000;
  localparam logic [15:0] FC_RESP       = 16'h8843;

  // addressing modes and field sizes in octets
  localparam logic [1:0] AM_SHORT       = 2'h2;
  localparam logic [1:0] AM_EXT         = 2'h3;
  localparam logic [3:0] PAN_OCTETS     = 4'h2;
  localparam logic [3:0] SHORT_OCTETS   = 4'h2;
  localparam logic [3:0] EXT_OCTETS     = 4'h8;

  // transmit request kinds
  localparam logic [1:0] KIND_DATA      = 2'h0;
  localparam logic [1:0] KIND_BEACON    = 2'h1;
  localparam logic [1:0] KIND_CMD       = 2'h2;
  localparam logic [1:0] KIND_ACK       = 2'h3;

  // fixed octets
  localparam logic [7:0] CMD_TONE_MAP_RESP = 8'h0A;
  localparam logic [7:0] GTS_SPEC_NONE     = 8'h00;
  localparam logic [7:0] PEND_ADDR_NONE    = 8'h00;
  localparam int         TM_PAYLOAD_OCTETS = 7;

  // prebuilt frame image lengths
  localparam int         BUF_DEPTH      = 20;
  localparam logic [4:0] HDR_LEN        = 5'h06;
  localparam logic [4:0] BEACON_LEN     = 5'h0E;
  localparam logic [4:0] RESP_LEN       = 5'h14;
  localparam logic [4:0] BODY_IDX       = 5'h1F;
  localparam logic [9:0] BEACON_SEG_LEN = 10'h00D;
  localparam logic [9:0] RESP_SEG_LEN   = 10'h013;

  // receive octet positions
  localparam logic [7:0] RX_SEQ_IDX     = 8'h05;
  localparam logic [7:0] RX_DPAN_IDX    = 8'h06;
  localparam logic [7:0] RX_IDX_MAX     = 8'hFF;

  typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_BODY} tx_state_type;

endpackage : framer_pkg
`default_nettype wire

// ==== mac_segment_header_framer.sv ====
// What this block does
// - Beacons we send carry no pending address list.
// - Beacons we send carry an empty payload.
// - No acknowledgement frame is ever built; acks go out as a pulse on the phy ack request.
// - The frame version bits of the frame control word are forced to zero and ignored.
// - Every MAC header starts with three segment control octets ahead of the frame control word.
// - Fields follow in order: segment control, frame control, sequence, destination pan and address, source pan and address, payload.
// - Bit 3 of octet 0 is the tone map request flag.
// - Bit 2 of octet 0 is the contention control flag.
// - Bit 1 of octet 0 is the access priority flag.
// - Bit 0 of octet 0 is the final segment flag.
// - Octet 1 holds the six-bit segment count over the top two length bits; octet 2 the rest.
// - A received tone map request with a short source address triggers a tone map response command frame to its sender.
`timescale 1ns/1ps
`default_nettype none
module mac_segment_header_framer (
  input  wire logic        ref_clk,                  // 100 MHz clock
  input  wire logic        rst_n,                    // synchronous reset, active low
  input  wire logic        tx_start,                 // frame request, taken while tx_idle
  input  wire logic [1:0]  tx_kind,                  // data, beacon, command or ack
  input  wire logic [15:0] tx_fc,                    // frame control word
  input  wire logic        tx_tmr,                   // tone map request flag
  input  wire logic        tx_cc,                    // contention control flag
  input  wire logic        tx_cap,                   // access priority flag
  input  wire logic        tx_final,                 // final segment flag
  input  wire logic [5:0]  tx_seg_count,             // segment counter
  input  wire logic [9:0]  tx_seg_len,               // segment length
  input  wire logic [15:0] tx_superframe,            // beacon superframe word
  input  wire logic [15:0] own_pan,                  // our pan id
  input  wire logic [15:0] own_short,                // our short address
  input  wire logic [55:0] tm_payload,               // tone map response payload
  output logic             tx_idle,                  // ready for a request
  output logic             tx_reject,                // request refused, pulse
  output logic             tm_resp_sent,             // response frame queued out, pulse
  input  wire logic [7:0]  body_data,                // body octet
  input  wire logic        body_valid,               // body octet valid
  input  wire logic        body_last,                // last body octet
  output logic             body_ready,               // body octet accepted
  output logic [7:0]       out_data,                 // frame octet out
  output logic             out_valid,                // frame octet valid
  output logic             out_last,                 // last octet of frame
  input  wire logic        out_ready,                // sink takes octet
  input  wire logic [7:0]  rx_data,                  // received octet
  input  wire logic        rx_valid,                 // received octet valid
  input  wire logic        rx_last,                  // last received octet
  output logic             rx_hdr_valid,             // header parsed, pulse
  output logic             rx_tmr,                   // tone map request flag
  output logic             rx_cc,                    // contention control flag
  output logic             rx_cap,                   // access priority flag
  output logic             rx_final,                 // final segment flag
  output logic [5:0]       rx_seg_count,             // segment counter
  output logic [9:0]       rx_seg_len,               // segment length
  output logic [15:0]      rx_fc,                    // frame control, version cleared
  output logic [7:0]       rx_seq,                   // sequence number
  output logic [15:0]      rx_src_short,             // sender short address
  output logic             phy_ack_request_primitive // ack request to phy, pulse
);

  // ==========================================================
  // receive parser
  field_sizes_if sizes ();
  addr_field_sizer u_sizer (.sz(sizes.sizer));

  logic [7:0]  rx_idx,   next_rx_idx;
  logic [15:0] rx_dpan,  next_rx_dpan;
  logic [15:0] rx_span,  next_rx_span;
  logic        src_ok,   next_src_ok;
  logic        resp_pending, next_resp_pending;
  logic [15:0] resp_pan, next_resp_pan;
  logic [15:0] resp_dst, next_resp_dst;
  logic        next_rx_hdr_valid, next_rx_tmr, next_rx_cc, next_rx_cap, next_rx_final;
  logic [5:0]  next_rx_seg_count;
  logic [9:0]  next_rx_seg_len;
  logic [15:0] next_rx_fc;
  logic [7:0]  next_rx_seq;
  logic [15:0] next_rx_src_short;
  logic        next_phy_ack;
  logic [7:0]  src_off;
  logic        resp_take;

  assign sizes.fc = rx_fc;

  // octet position decode of the incoming header
  always_comb begin
    next_rx_idx = rx_idx;  next_rx_dpan = rx_dpan;  next_rx_span = rx_span;
    next_src_ok = src_ok;  next_resp_pan = resp_pan;  next_resp_dst = resp_dst;
    next_rx_tmr = rx_tmr;  next_rx_cc = rx_cc;  next_rx_cap = rx_cap;
    next_rx_final = rx_final;  next_rx_seg_count = rx_seg_count;
    next_rx_seg_len = rx_seg_len;  next_rx_fc = rx_fc;  next_rx_seq = rx_seq;
    next_rx_src_short = rx_src_short;
    next_rx_hdr_valid = 1'b0;
    next_phy_ack = 1'b0;
    next_resp_pending = resp_pending & ~resp_take;
    src_off = RX_DPAN_IDX_SUM();
    if (rx_valid) begin
      case (rx_idx)
        8'h00: begin
          next_rx_tmr   = rx_data[framer_pkg::SC0_TMR_BIT];
          next_rx_cc    = rx_data[framer_pkg::SC0_CC_BIT];
          next_rx_cap   = rx_data[framer_pkg::SC0_CAP_BIT];
          next_rx_final = rx_data[framer_pkg::SC0_FINAL_BIT];
          next_src_ok   = 1'b0;
        end
        8'h01: begin
          next_rx_seg_count     = rx_data[7:framer_pkg::SC1_COUNT_LSB];
          next_rx_seg_len[9:8]  = rx_data[1:0];
        end
        8'h02: next_rx_seg_len[7:0] = rx_data;
        8'h03: next_rx_fc[7:0]      = rx_data;
        8'h04: next_rx_fc[15:8]     = rx_data & framer_pkg::FC_VER_MASK[15:8];
        8'h05: begin
          next_rx_seq       = rx_data;
          next_rx_hdr_valid = 1'b1;
        end
        default: ;
      endcase
      // pan and address fields sit at offsets set by the addressing modes
      if (rx_idx == framer_pkg::RX_DPAN_IDX) next_rx_dpan[7:0] = rx_data;
      if (rx_idx == framer_pkg::RX_DPAN_IDX + 8'h01) next_rx_dpan[15:8] = rx_data;
      if (sizes.span_len != 4'h0 && rx_idx == src_off - 8'h02) next_rx_span[7:0] = rx_data;
      if (sizes.span_len != 4'h0 && rx_idx == src_off - 8'h01) next_rx_span[15:8] = rx_data;
      if (sizes.saddr_len == framer_pkg::SHORT_OCTETS && rx_idx == src_off)
        next_rx_src_short[7:0] = rx_data;
      if (sizes.saddr_len == framer_pkg::SHORT_OCTETS && rx_idx == src_off + 8'h01) begin
        next_rx_src_short[15:8] = rx_data;
        next_src_ok = 1'b1;
      end
      if (rx_last) begin
        next_rx_idx = 8'h00;
        if (rx_idx >= framer_pkg::RX_SEQ_IDX) begin
          next_phy_ack = rx_fc[framer_pkg::FC_ACKREQ_BIT];
          if (rx_tmr && src_ok) begin
            next_resp_pending = 1'b1;
            next_resp_dst     = rx_src_short;
            next_resp_pan     = (sizes.span_len != 4'h0) ? rx_span : rx_dpan;
          end
        end
      end else if (rx_idx != framer_pkg::RX_IDX_MAX) begin
        next_rx_idx = rx_idx + 8'h01;
      end
    end
  end

  function automatic logic [7:0] RX_DPAN_IDX_SUM();
    RX_DPAN_IDX_SUM = framer_pkg::RX_DPAN_IDX + {4'h0, sizes.dpan_len}
                    + {4'h0, sizes.daddr_len} + {4'h0, sizes.span_len};
  endfunction : RX_DPAN_IDX_SUM

  // receive registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_idx <= 8'h00;  rx_dpan <= 16'h0000;  rx_span <= 16'h0000;  src_ok <= 1'b0;
      resp_pending <= 1'b0;  resp_pan <= 16'h0000;  resp_dst <= 16'h0000;
      rx_hdr_valid <= 1'b0;  rx_tmr <= 1'b0;  rx_cc <= 1'b0;  rx_cap <= 1'b0;
      rx_final <= 1'b0;  rx_seg_count <= 6'h00;  rx_seg_len <= 10'h000;
      rx_fc <= 16'h0000;  rx_seq <= 8'h00;  rx_src_short <= 16'h0000;
      phy_ack_request_primitive <= 1'b0;
    end else begin
      rx_idx <= next_rx_idx;  rx_dpan <= next_rx_dpan;  rx_span <= next_rx_span;
      src_ok <= next_src_ok;  resp_pending <= next_resp_pending;
      resp_pan <= next_resp_pan;  resp_dst <= next_resp_dst;
      rx_hdr_valid <= next_rx_hdr_valid;  rx_tmr <= next_rx_tmr;  rx_cc <= next_rx_cc;
      rx_cap <= next_rx_cap;  rx_final <= next_rx_final;
      rx_seg_count <= next_rx_seg_count;  rx_seg_len <= next_rx_seg_len;
      rx_fc <= next_rx_fc;  rx_seq <= next_rx_seq;  rx_src_short <= next_rx_src_short;
      phy_ack_request_primitive <= next_phy_ack;
    end
  end

  // ==========================================================
  // transmit framer
  framer_pkg::tx_state_type state, next_state;
  logic [7:0] frame_buf [framer_pkg::BUF_DEPTH];
  logic [7:0] next_buf  [framer_pkg::BUF_DEPTH];
  logic [7:0] img       [framer_pkg::BUF_DEPTH];
  logic [4:0] img_len, len, next_len, pos, next_pos, out_idx, next_out_idx;
  logic       img_stream, stream, next_stream;
  logic       cur_beacon, next_cur_beacon, cur_resp, next_cur_resp;
  logic [7:0] seq, next_seq, next_out_data;
  logic       user_go, use_resp, load;
  logic       next_tx_idle, next_tx_reject, next_tm_resp_sent;
  logic       next_body_ready, next_out_valid, next_out_last;
  logic [7:0] sc0;

  assign user_go  = tx_start && tx_idle;
  assign use_resp = !user_go;

  // frame image: segment control first, then the header octets
  always_comb begin
    for (int i = 0; i < framer_pkg::BUF_DEPTH; i++) img[i] = 8'h00;
    sc0 = {framer_pkg::SC0_RES_VALUE, tx_tmr, tx_cc, tx_cap, tx_final};
    img[0] = sc0;
    img[1] = {tx_seg_count, tx_seg_len[9:8]};
    img[2] = tx_seg_len[7:0];
    img[3] = tx_fc[7:0];
    img[4] = tx_fc[15:8] & framer_pkg::FC_VER_MASK[15:8];
    img[5] = seq;
    img_len    = framer_pkg::HDR_LEN;
    img_stream = 1'b1;
    if (use_resp) begin
      img[0] = {framer_pkg::SC0_RES_VALUE, 4'h1};
      img[1] = {6'h00, framer_pkg::RESP_SEG_LEN[9:8]};
      img[2] = framer_pkg::RESP_SEG_LEN[7:0];
      img[3] = framer_pkg::FC_RESP[7:0];
      img[4] = framer_pkg::FC_RESP[15:8];
      img[6] = resp_pan[7:0];   img[7] = resp_pan[15:8];
      img[8] = resp_dst[7:0];   img[9] = resp_dst[15:8];
      img[10] = own_short[7:0]; img[11] = own_short[15:8];
      img[12] = framer_pkg::CMD_TONE_MAP_RESP;
      for (int j = 0; j < framer_pkg::TM_PAYLOAD_OCTETS; j++) img[13 + j] = tm_payload[8*j +: 8];
      img_len    = framer_pkg::RESP_LEN;
      img_stream = 1'b0;
    end else if (tx_kind == framer_pkg::KIND_BEACON) begin
      img[0] = {framer_pkg::SC0_RES_VALUE, 1'b0, tx_cc, tx_cap, 1'b1};
      img[1] = {6'h00, framer_pkg::BEACON_SEG_LEN[9:8]};
      img[2] = framer_pkg::BEACON_SEG_LEN[7:0];
      img[3] = framer_pkg::FC_BEACON[7:0];
      img[4] = framer_pkg::FC_BEACON[15:8];
      img[6] = own_pan[7:0];       img[7] = own_pan[15:8];
      img[8] = own_short[7:0];     img[9] = own_short[15:8];
      img[10] = tx_superframe[7:0]; img[11] = tx_superframe[15:8];
      img[12] = framer_pkg::GTS_SPEC_NONE;
      img[13] = framer_pkg::PEND_ADDR_NONE;
      img_len    = framer_pkg::BEACON_LEN;
      img_stream = 1'b0;
    end
  end

  // request intake, header emission and body pass-through
  always_comb begin
    next_state = state;  next_len = len;  next_pos = pos;  next_stream = stream;
    next_cur_beacon = cur_beacon;  next_cur_resp = cur_resp;  next_seq = seq;
    next_out_idx = out_idx;  next_out_data = out_data;  next_out_last = out_last;
    next_out_valid = out_valid && !out_ready;
    next_body_ready = body_ready;
    next_tx_reject = 1'b0;  next_tm_resp_sent = 1'b0;
    resp_take = 1'b0;  load = 1'b0;
    case (state)
      framer_pkg::TX_IDLE: begin
        if (user_go) begin
          if (tx_kind == framer_pkg::KIND_ACK) next_tx_reject = 1'b1;
          else load = 1'b1;
        end else if (resp_pending && tx_idle) begin
          load = 1'b1;
          resp_take = 1'b1;
        end
      end
      framer_pkg::TX_HDR: begin
        if (!out_valid || out_ready) begin
          next_out_data  = frame_buf[pos];
          next_out_valid = 1'b1;
          next_out_idx   = pos;
          next_out_last  = (pos == len - 5'h01) && !stream;
          next_pos       = pos + 5'h01;
          if (pos == len - 5'h01) begin
            next_state        = stream ? framer_pkg::TX_BODY : framer_pkg::TX_IDLE;
            next_tm_resp_sent = cur_resp && !stream;
          end
        end
      end
      framer_pkg::TX_BODY: begin
        if (body_ready && body_valid) begin
          next_body_ready = 1'b0;
          next_out_data   = body_data;
          next_out_valid  = 1'b1;
          next_out_idx    = framer_pkg::BODY_IDX;
          next_out_last   = body_last;
          if (body_last) next_state = framer_pkg::TX_IDLE;
        end else if (!body_ready && (!out_valid || out_ready)) begin
          next_body_ready = 1'b1;
        end
      end
      default: next_state = framer_pkg::TX_IDLE;
    endcase
    if (load) begin
      next_state = framer_pkg::TX_HDR;  next_len = img_len;  next_stream = img_stream;
      next_pos = 5'h00;  next_seq = seq + 8'h01;  next_cur_resp = use_resp;
      next_cur_beacon = !use_resp && (tx_kind == framer_pkg::KIND_BEACON);
    end
    for (int k = 0; k < framer_pkg::BUF_DEPTH; k++) next_buf[k] = load ? img[k] : frame_buf[k];
    next_tx_idle = (next_state == framer_pkg::TX_IDLE) && !next_out_valid;
  end

  // transmit registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= framer_pkg::TX_IDLE;  len <= 5'h00;  pos <= 5'h00;  stream <= 1'b0;
      cur_beacon <= 1'b0;  cur_resp <= 1'b0;  seq <= 8'h00;  out_idx <= 5'h00;
      out_data <= 8'h00;  out_valid <= 1'b0;  out_last <= 1'b0;  body_ready <= 1'b0;
      tx_idle <= 1'b0;  tx_reject <= 1'b0;  tm_resp_sent <= 1'b0;
      for (int k = 0; k < framer_pkg::BUF_DEPTH; k++) frame_buf[k] <= 8'h00;
    end else begin
      state <= next_state;  len <= next_len;  pos <= next_pos;  stream <= next_stream;
      cur_beacon <= next_cur_beacon;  cur_resp <= next_cur_resp;  seq <= next_seq;
      out_idx <= next_out_idx;  out_data <= next_out_data;  out_valid <= next_out_valid;
      out_last <= next_out_last;  body_ready <= next_body_ready;
      tx_idle <= next_tx_idle;  tx_reject <= next_tx_reject;  tm_resp_sent <= next_tm_resp_sent;
      for (int k = 0; k < framer_pkg::BUF_DEPTH; k++) frame_buf[k] <= next_buf[k];
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_beacon_no_pend: assert property (out_valid && out_last && cur_beacon |-> out_data == 8'h00)
    else $error("beacon ends with a nonzero pending address octet");
  a_beacon_empty_payload: assert property (out_valid && out_last && cur_beacon |-> out_idx == 5'h0D)
    else $error("beacon length is not fourteen octets");
  a_ack_refused: assert property (tx_start && tx_idle && tx_kind == 2'h3 |=> tx_reject ##1 !out_valid)
    else $error("ack request was not refused");
  a_version_zero: assert property (out_valid && out_idx == 5'h04 |-> out_data[5:4] == 2'h0)
    else $error("frame version bits sent nonzero");
  a_rx_version_zero: assert property (rx_hdr_valid |-> rx_fc[13:12] == 2'h0)
    else $error("received frame version not cleared");
  a_start_sc_first: assert property (tx_start && tx_idle && tx_kind != 2'h3 |-> ##2 out_valid && out_idx == 5'h00)
    else $error("frame did not start with segment control octet 0");
  a_reserved_zero: assert property (out_valid && out_idx == 5'h00 |-> out_data[7:4] == 4'h0)
    else $error("reserved segment control bits nonzero");
  a_resp_final: assert property (out_valid && cur_resp && out_idx == 5'h00 |-> out_data == 8'h01)
    else $error("tone map response is not a lone final segment");
  a_seq_octet: assert property (out_valid && out_idx == 5'h05 |-> out_data == 8'(seq - 8'h01))
    else $error("sequence octet mismatch");
  a_tmr_answered: assert property (rx_valid && rx_last && rx_tmr && src_ok && rx_idx >= 8'h05 |=> resp_pending)
    else $error("tone map request not queued for response");

  c_beacon_sent: cover property (out_valid && out_ready && out_last && cur_beacon);
  c_resp_sent:   cover property (tm_resp_sent);
  c_ack_pulse:   cover property (phy_ack_request_primitive);
  c_body_end:    cover property (out_valid && out_ready && out_last && out_idx == 5'h1F);

endmodule : mac_segment_header_framer
`default_nettype wire

// ==== mac_segment_header_framer_test.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// self-checking bench of the segment header framer
module mac_segment_header_framer_test;
  logic ref_clk = 0, rst_n = 0, tx_start = 0, tx_tmr = 0, tx_cc = 0, tx_cap = 0, tx_final = 0;
  logic [1:0] tx_kind = 0;
  logic [15:0] tx_fc = 0, rx_fc, rx_src_short;
  logic [5:0] tx_seg_count = 0, rx_seg_count;
  logic [9:0] tx_seg_len = 0, rx_seg_len;
  logic [7:0] body_data = 0, out_data, rx_data, rx_seq;
  logic body_valid = 0, body_last = 0, body_ready, out_valid, out_last, out_ready, rx_valid;
  logic rx_last, tx_idle, tx_reject, tm_resp_sent, rx_hdr_valid, rx_tmr, rx_cc, rx_cap, rx_final;
  logic phy_ack_request_primitive;
  logic [15:0] tx_superframe = 16'hC0DE, own_pan = 16'h1234, own_short = 16'h5678;
  logic [55:0] tm_payload = 56'h06050403020100;
  int num_errors = 0, samples_checked = 0, acks = 0, resps = 0, hdrs = 0, ends = 0;
  mac_segment_header_framer u_dut (.*);
  peer_mac u_peer (.*);
  always #5 ref_clk = ~ref_clk;
  // count single-cycle pulses and frame ends taken by the sink
  always @(posedge ref_clk) begin
    {acks, resps} <= {acks + phy_ack_request_primitive, resps + tm_resp_sent};
    {hdrs, ends}  <= {hdrs + rx_hdr_valid, ends + (out_valid && out_ready && out_last)};
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // wait for n collected octets and the block idle again, bounded
  task automatic wait_for(input int n);
    int k;
    for (k = 0; k < 500 && !(u_peer.got.size() >= n && tx_idle === 1'b1); k++) @(posedge ref_clk) #1;
    if (k == 500) begin num_errors++; give_verdict(); end
  endtask : wait_for
  // compare collected octets against a table; skip marks a free position
  task automatic frame_is(input string what, input logic [7:0] e[], input int skip);
    wait_for(e.size());
    check({what, " length"}, u_peer.got.size(), e.size());
    foreach (e[i]) if (i != skip) check(what, u_peer.got[i], e[i]);
    u_peer.got.delete();
  endtask : frame_is
  task automatic start(input logic [1:0] kind);
    wait_for(0);
    tx_kind = kind;
    tx_start = 1'b1;
    @(posedge ref_clk) #1 tx_start = 1'b0;
  endtask : start
  // data frame with every segment control field set off-centre, version bits set
  task automatic test_data();
    {tx_tmr, tx_cc, tx_cap, tx_final, tx_seg_count, tx_seg_len, tx_fc} = {4'hB, 6'h2A, 10'h2B7, 16'h3041};
    {body_data, body_valid, body_last} = {8'hA5, 2'b11};
    start(2'h0);
    for (int k = 0; k < 100 && body_ready !== 1'b1; k++) @(posedge ref_clk) #1;
    check("body ready", body_ready, 1'b1);
    // hold the body octet through the edge that takes it
    @(posedge ref_clk) #1 {body_valid, body_last} = 2'b00;
    frame_is("data", '{8'h0B, 8'hAA, 8'hB7, 8'h41, 8'h00, 8'h00, 8'hA5}, -1);
    check("data end", ends, 1);
    $display("data frame done");
  endtask : test_data
  // beacon through a stalling sink: empty payload, no pending list
  task automatic test_beacon();
    {u_peer.slow, tx_cc, tx_cap} = 3'b110;
    start(2'h1);
    frame_is("beacon", '{8'h05, 8'h00, 8'h0D, 8'h00, 8'h80, 8'h01, 8'h34, 8'h12, 8'h78, 8'h56,
             8'hDE, 8'hC0, 8'h00, 8'h00}, -1);
    check("beacon end", ends, 2);
    u_peer.slow = 1'b0;
    $display("beacon done");
  endtask : test_beacon
  // ack kind is refused and nothing reaches the line
  task automatic test_ack();
    start(2'h3);
    check("reject", tx_reject, 1'b1);
    repeat (8) @(posedge ref_clk);
    check("ack octets", u_peer.got.size(), 0);
    $display("ack refusal done");
  endtask : test_ack
  // received header with tone map request, ack request and version bits
  task automatic test_rx();
    u_peer.send('{8'h08, 8'h06, 8'h10, 8'h61, 8'h98, 8'h33, 8'h34, 8'h12, 8'h78, 8'h56, 8'hCD, 8'hAB,
                  8'h11, 8'h00, 8'h00});
    check("rx flags", {rx_tmr, rx_cc, rx_cap, rx_final}, 4'h8);
    check("rx count", rx_seg_count, 6'h01);
    check("rx length", rx_seg_len, 10'h210);
    check("rx fc", rx_fc, 16'h8861);
    check("rx seq", rx_seq, 8'h33);
    check("rx source", rx_src_short, 16'hABCD);
    check("hdr pulses", hdrs, 1);
    frame_is("tone map resp", '{8'h01, 8'h00, 8'h13, 8'h43, 8'h88, 8'h02, 8'h34, 8'h12, 8'hCD, 8'hAB,
             8'h78, 8'h56, 8'h0A, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06}, -1);
    check("resp end", ends, 3);
    check("ack pulses", acks, 1);
    check("resp pulses", resps, 1);
    $display("receive done");
  endtask : test_rx
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    test_data();
    test_beacon();
    test_ack();
    test_rx();
    give_verdict();
  end
endmodule : mac_segment_header_framer_test
`default_nettype wire

// ==== peer_mac.sv ====
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// far end modem: sink of framed octets and source of received frames
module peer_mac (
  input  wire logic       ref_clk,   // clock
  input  wire logic [7:0] out_data,  // framed octet
  input  wire logic       out_valid, // octet valid
  input  wire logic       out_last,  // last octet
  output logic            out_ready, // sink ready
  output logic [7:0]      rx_data,   // octet to block
  output logic            rx_valid,  // octet valid
  output logic            rx_last    // last octet of frame
);
  logic [7:0] got[$];     // octets taken, in wire order
  logic       slow = 1'b0; // stall every other cycle
  initial {out_ready, rx_data, rx_valid, rx_last} = 11'h000;
  // sink takes octets in order 0, 1, 2 and on, stalling when slow
  always @(posedge ref_clk) begin
    if (out_valid && out_ready) got.push_back(out_data);
    out_ready <= #1 slow ? ~out_ready : 1'b1;
  end
  // source sends a whole frame, one octet a cycle; idle line is inverted
  task automatic send(input logic [7:0] f[]);
    for (int i = 0; i < f.size(); i++) begin
      @(posedge ref_clk) #1 {rx_data, rx_valid, rx_last} = {f[i], 1'b1, i == f.size() - 1};
    end
    @(posedge ref_clk) #1 {rx_data, rx_valid, rx_last} = {~rx_data, 2'b00};
  endtask : send
endmodule : peer_mac
`default_nettype wire
